// ===== logic/twc_pkg.sv
// constants, types and decode helpers for the timer waveform output block
`default_nettype none
package twc_pkg;
   // ********************************
   // register map
   // ********************************
   localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
   localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
   localparam logic [7:0] ADDR_COUNT  = 8'hb2;
   localparam logic [7:0] ADDR_CMP_A  = 8'hb3;
   localparam logic [7:0] ADDR_CMP_B  = 8'hb4;
   localparam logic [7:0] ADDR_STATUS = 8'hb5;
   localparam logic [7:0] ADDR_MASK   = 8'hb6;
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [7:0] CTRL_A_MASK = 8'hf3; // bits 3:2 read zero
   localparam int         COM_A_LSB   = 6;
   localparam int         COM_B_LSB   = 4;
   localparam int         MODE_HI_BIT = 3;     // in waveform_control_b
   localparam int         ST_OVF      = 0;
   localparam int         ST_MATCH_A  = 1;
   localparam int         ST_MATCH_B  = 2;
   localparam int         ST_W        = 3;
   // ********************************
   // counter and output codes
   // ********************************
   localparam logic [7:0] CNT_MAX    = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_ONE    = 8'h01;
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;
   localparam logic [2:0] MODE_NORMAL  = 3'h0;
   localparam logic [2:0] MODE_PHASE   = 3'h1;
   localparam logic [2:0] MODE_CTC     = 3'h2;
   localparam logic [2:0] MODE_FAST    = 3'h3;
   localparam logic [2:0] MODE_PHASE_A = 3'h5;
   localparam logic [2:0] MODE_FAST_A  = 3'h7;

   typedef enum logic [2:0] {
      TWC_K_NORMAL, TWC_K_CTC, TWC_K_FAST, TWC_K_PHASE, TWC_K_RSVD
   } twc_kind_e;

   // waveform kind of a three-bit mode
   function automatic twc_kind_e kind_of(input logic [2:0] mode);
      case (mode)
         MODE_NORMAL:               kind_of = TWC_K_NORMAL;
         MODE_CTC:                  kind_of = TWC_K_CTC;
         MODE_FAST, MODE_FAST_A:    kind_of = TWC_K_FAST;
         MODE_PHASE, MODE_PHASE_A:  kind_of = TWC_K_PHASE;
         default:                   kind_of = TWC_K_RSVD;
      endcase
   endfunction

   // counter ceiling: fixed max or compare value a
   function automatic logic [7:0] top_of(input logic [2:0] mode,
                                         input logic [7:0] cmp_a);
      case (mode)
         MODE_CTC, MODE_PHASE_A, MODE_FAST_A: top_of = cmp_a;
         default:                             top_of = CNT_MAX;
      endcase
   endfunction
endpackage
`default_nettype wire

// ===== logic/twc_counter.sv
// eight-bit up or up-down counter following the waveform kind
`timescale 1ns/1ns
`default_nettype none
module twc_counter (
   input  wire logic              clk_i,   // timer clock
   input  wire logic              nrst_i,  // async reset, low
   input  wire twc_pkg::twc_kind_e kind_i, // decoded mode
   input  wire logic [7:0]        top_i,   // ceiling value
   output logic      [7:0]        count_o, // counter value
   output logic                   down_o   // counting down
);
   // ********************************
   // count sequence
   // ********************************
   // reserved kinds run as normal so nothing stalls
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_o <= twc_pkg::CNT_BOTTOM;
         down_o  <= 1'b0;
      end else begin
         case (kind_i)
            twc_pkg::TWC_K_CTC, twc_pkg::TWC_K_FAST: begin
               down_o  <= 1'b0;
               count_o <= (count_o >= top_i) ? twc_pkg::CNT_BOTTOM
                                             : count_o + twc_pkg::CNT_ONE;
            end
            twc_pkg::TWC_K_PHASE: begin
               // a zero ceiling would otherwise underflow
               if (top_i == twc_pkg::CNT_BOTTOM) begin
                  count_o <= twc_pkg::CNT_BOTTOM;
                  down_o  <= 1'b0;
               end else if (!down_o && count_o >= top_i) begin
                  down_o  <= 1'b1;
                  count_o <= count_o - twc_pkg::CNT_ONE;
               end else if (down_o && count_o == twc_pkg::CNT_BOTTOM) begin
                  down_o  <= 1'b0;
                  count_o <= twc_pkg::CNT_ONE;
               end else if (down_o) begin
                  count_o <= count_o - twc_pkg::CNT_ONE;
               end else begin
                  count_o <= count_o + twc_pkg::CNT_ONE;
               end
            end
            default: begin
               down_o  <= 1'b0;
               count_o <= count_o + twc_pkg::CNT_ONE;
            end
         endcase
      end
   end
endmodule // twc_counter
`default_nettype wire

// ===== logic/twc_channel.sv
// one compare output channel: pin takeover and set, clear, toggle
`timescale 1ns/1ns
`default_nettype none
module twc_channel (
   input  wire logic               clk_i,      // timer clock
   input  wire logic               nrst_i,     // async reset, low
   input  wire twc_pkg::twc_kind_e kind_i,     // decoded mode
   input  wire logic [1:0]         com_i,      // output mode
   input  wire logic               tgl_ok_i,   // pwm toggle allowed
   input  wire logic               match_i,    // count equals compare
   input  wire logic               eq_top_i,   // compare equals top
   input  wire logic               bottom_i,   // count is zero
   input  wire logic               top_i,      // count is top
   input  wire logic               down_i,     // counting down
   output logic                    wave_o,     // waveform level
   output logic                    en_o        // pin taken over
);
   logic next_wave;

   // ********************************
   // output level
   // ********************************
   always_comb begin
      next_wave = wave_o;
      case (kind_i)
         twc_pkg::TWC_K_NORMAL, twc_pkg::TWC_K_CTC: begin
            if (match_i && com_i == twc_pkg::COM_TOGGLE) next_wave = ~wave_o;
            if (match_i && com_i[1]) next_wave = com_i[0];
         end
         // fast pwm, clear or set on a match at top ignored; toggle still acts
         twc_pkg::TWC_K_FAST: begin
            if (com_i[1] && bottom_i) next_wave = ~com_i[0];
            if (com_i[1] && match_i && !eq_top_i) next_wave = com_i[0];
            if (com_i == twc_pkg::COM_TOGGLE && tgl_ok_i && match_i) next_wave = ~wave_o;
         end
         // phase pwm, clear or set on a match at top done at top instead
         twc_pkg::TWC_K_PHASE: begin
            if (com_i[1] && eq_top_i && top_i) next_wave = com_i[0];
            if (com_i[1] && !eq_top_i && match_i) next_wave = com_i[0] ^ down_i;
            if (com_i == twc_pkg::COM_TOGGLE && tgl_ok_i && match_i) next_wave = ~wave_o;
         end
         default: next_wave = wave_o;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) wave_o <= 1'b0;
      else         wave_o <= next_wave;
   end

   // pwm toggle code without permission stays off
   // reserved modes leave the pin alone
   always_comb begin
      en_o = (com_i != twc_pkg::COM_OFF) && (kind_i != twc_pkg::TWC_K_RSVD);
      if ((kind_i == twc_pkg::TWC_K_FAST || kind_i == twc_pkg::TWC_K_PHASE)
          && com_i == twc_pkg::COM_TOGGLE && !tgl_ok_i) en_o = 1'b0;
   end

   // ********************************
   // checks
   // ********************************
   a_chan_clear_level: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind_i == twc_pkg::TWC_K_CTC && com_i == twc_pkg::COM_CLEAR && match_i)
      |=> !wave_o)
      else $error("clear on match did not clear");
endmodule // twc_channel
`default_nettype wire

// ===== logic/twc_top.sv
// timer waveform output control: registers, counter, two channels
//
// What this block does
// - control a holds mode a 7:6, mode b 5:4, low mode 1:0; 3:2 read zero
// - nonzero output mode a hands pin a to the waveform, except in reserved modes 4 and 6 and for 01 in pwm modes 1 and 3
// - nonzero output mode b hands pin b to the waveform, except in reserved modes 4 and 6 and for 01 in any pwm mode
// - non-pwm mode a: toggle, clear or set on match; zero disconnects
// - non-pwm channel b behaves exactly like channel a
// - fast pwm: 10 clear on match set at bottom; 11 inverse; b 01 reserved
// - pwm mode a 01 toggles only with high mode bit set, else disconnected
// - phase pwm: 10 clear going up, set going down; 11 reverse
// - fast pwm, compare equals top: clear or set on match ignored, bottom action kept; toggle still acts
// - phase pwm, compare equals top: clear or set on match ignored, action done at top
// - three-bit mode from high bit and low bits picks sequence and top
// - mode 0 normal, mode 2 clear-on-match; immediate update, overflow at max
// - modes 1 and 5 phase pwm; update at top, overflow at bottom
// - modes 3 and 7 fast pwm; update at bottom; 4 and 6 reserved
// - high mode bit sits at bit 3 of control b
`timescale 1ns/1ns
`default_nettype none
module twc_top (
   input  wire logic       clk_i,       // 100 MHz timer clock
   input  wire logic       nrst_i,      // async reset, low
   input  wire logic [7:0] addr_i,      // register address
   input  wire logic [7:0] wdata_i,     // write data
   input  wire logic       wr_i,        // write strobe
   input  wire logic       rd_i,        // read strobe
   output logic      [7:0] rdata_o,     // read data, next cycle
   output logic            wave_a_o,    // wave_out_a level
   output logic            wave_a_en_o, // wave_out_a owns pin
   output logic            wave_b_o,    // wave_out_b level
   output logic            wave_b_en_o, // wave_out_b owns pin
   output logic            irq_o        // level interrupt
);
   // ********************************
   // storage
   // ********************************
   logic [7:0]              ctrl_a;      // waveform_control_a
   logic                    mode_high;   // waveform_mode_high
   logic [7:0]              cmp_buf_a;   // compare_value_a as written
   logic [7:0]              cmp_buf_b;   // compare_value_b as written
   logic [7:0]              cmp_a;       // active compare a
   logic [7:0]              cmp_b;       // active compare b
   logic [twc_pkg::ST_W-1:0] status;     // sticky events
   logic [twc_pkg::ST_W-1:0] mask;       // event enables
   logic [7:0]              next_rdata;
   logic [2:0]              mode;
   twc_pkg::twc_kind_e      kind;
   logic [7:0]              top;
   logic [7:0]              count;
   logic                    down;
   logic [1:0]              com_a;
   logic [1:0]              com_b;
   logic                    at_top;
   logic                    at_bottom;
   logic                    match_a;
   logic                    match_b;
   logic                    ovf_evt;
   logic                    load_cmp;
   logic [twc_pkg::ST_W-1:0] evt;
   logic [twc_pkg::ST_W-1:0] clr;

   // ********************************
   // decode
   // ********************************
   // mode built from high and low bits
   // high bit lives in control b
   assign mode  = {mode_high, ctrl_a[1:0]};
   assign kind  = twc_pkg::kind_of(mode);
   assign top   = twc_pkg::top_of(mode, cmp_a);
   assign com_a = ctrl_a[twc_pkg::COM_A_LSB +: 2];
   assign com_b = ctrl_a[twc_pkg::COM_B_LSB +: 2];

   // bottom is a count of zero
   assign at_bottom = (count == twc_pkg::CNT_BOTTOM);
   assign at_top    = (count == top);
   assign match_a   = (count == cmp_a);
   assign match_b   = (count == cmp_b);

   // ********************************
   // register writes
   // ********************************
   // reserved bits never stored
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_a <= twc_pkg::RESET_BYTE;
      end else if (wr_i && addr_i == twc_pkg::ADDR_CTRL_A) begin
         ctrl_a <= wdata_i & twc_pkg::CTRL_A_MASK;
      end
   end

   // only bit 3 of control b exists here
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_high <= 1'b0;
      end else if (wr_i && addr_i == twc_pkg::ADDR_CTRL_B) begin
         mode_high <= wdata_i[twc_pkg::MODE_HI_BIT];
      end
   end

   // software side of the compare values
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmp_buf_a <= twc_pkg::RESET_BYTE;
         cmp_buf_b <= twc_pkg::RESET_BYTE;
      end else begin
         if (wr_i && addr_i == twc_pkg::ADDR_CMP_A) cmp_buf_a <= wdata_i;
         if (wr_i && addr_i == twc_pkg::ADDR_CMP_B) cmp_buf_b <= wdata_i;
      end
   end

   // ********************************
   // compare update timing
   // ********************************
   // immediate in normal and clear-on-match
   // at bottom in fast pwm
   // double buffering keeps pwm edges glitch free mid-period
   always_comb begin
      case (kind)
         twc_pkg::TWC_K_PHASE: load_cmp = at_top;
         twc_pkg::TWC_K_FAST:  load_cmp = at_bottom;
         default:              load_cmp = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmp_a <= twc_pkg::RESET_BYTE;
         cmp_b <= twc_pkg::RESET_BYTE;
      end else if (load_cmp) begin
         cmp_a <= cmp_buf_a;
         cmp_b <= cmp_buf_b;
      end
   end

   // ********************************
   // counter and channels
   // ********************************
   twc_counter u_counter (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .kind_i  (kind),
      .top_i   (top),
      .count_o (count),
      .down_o  (down)
   );

   // pin a taken when mode a nonzero and mode not reserved
   // high mode bit gates the pwm toggle
   twc_channel u_chan_a (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .kind_i   (kind),
      .com_i    (com_a),
      .tgl_ok_i (mode_high),
      .match_i  (match_a),
      .eq_top_i (cmp_a == top),
      .bottom_i (at_bottom),
      .top_i    (at_top),
      .down_i   (down),
      .wave_o   (wave_a_o),
      .en_o     (wave_a_en_o)
   );

   // pin b taken when mode b nonzero and mode not reserved
   // same behaviour, toggle code reserved in pwm
   twc_channel u_chan_b (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .kind_i   (kind),
      .com_i    (com_b),
      .tgl_ok_i (1'b0),
      .match_i  (match_b),
      .eq_top_i (cmp_b == top),
      .bottom_i (at_bottom),
      .top_i    (at_top),
      .down_i   (down),
      .wave_o   (wave_b_o),
      .en_o     (wave_b_en_o)
   );

   // ********************************
   // events and interrupt
   // ********************************
   // overflow at max, at bottom, max or top
   always_comb begin
      case (kind)
         twc_pkg::TWC_K_PHASE: ovf_evt = at_bottom && down;
         twc_pkg::TWC_K_FAST:  ovf_evt = (mode == twc_pkg::MODE_FAST_A) ? at_top
                                       : (count == twc_pkg::CNT_MAX);
         default:              ovf_evt = (count == twc_pkg::CNT_MAX);
      endcase
   end

   assign evt = {match_b, match_a, ovf_evt};
   assign clr = (wr_i && addr_i == twc_pkg::ADDR_STATUS) ? wdata_i[twc_pkg::ST_W-1:0]
                                                         : '0;

   // write one clears; a new event in the same cycle wins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) status <= '0;
      else         status <= (status & ~clr) | evt;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask <= '0;
      end else if (wr_i && addr_i == twc_pkg::ADDR_MASK) begin
         mask <= wdata_i[twc_pkg::ST_W-1:0];
      end
   end

   assign irq_o = |(status & mask);

   // ********************************
   // register reads
   // ********************************
   // unmapped addresses read zero
   always_comb begin
      next_rdata = twc_pkg::RESET_BYTE;
      if (rd_i) begin
         case (addr_i)
            twc_pkg::ADDR_CTRL_A: next_rdata = ctrl_a & twc_pkg::CTRL_A_MASK;
            twc_pkg::ADDR_CTRL_B: next_rdata = 8'(mode_high) << twc_pkg::MODE_HI_BIT;
            twc_pkg::ADDR_COUNT:  next_rdata = count;
            twc_pkg::ADDR_CMP_A:  next_rdata = cmp_buf_a;
            twc_pkg::ADDR_CMP_B:  next_rdata = cmp_buf_b;
            twc_pkg::ADDR_STATUS: next_rdata = 8'(status);
            twc_pkg::ADDR_MASK:   next_rdata = 8'(mask);
            default:              next_rdata = twc_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) rdata_o <= twc_pkg::RESET_BYTE;
      else         rdata_o <= next_rdata;
   end

   // ********************************
   // checks
   // ********************************
   a_reserved_bits_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (rd_i && addr_i == twc_pkg::ADDR_CTRL_A) |=> (rdata_o[3:2] == 2'h0))
      else $error("reserved control bits read nonzero");

   a_pin_take_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (com_a != twc_pkg::COM_OFF && (kind == twc_pkg::TWC_K_NORMAL
       || kind == twc_pkg::TWC_K_CTC)) |-> wave_a_en_o)
      else $error("pin a not taken over");

   a_pin_free_b: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (com_b == twc_pkg::COM_OFF) |-> !wave_b_en_o)
      else $error("pin b taken with mode zero");

   a_toggle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_NORMAL && com_a == twc_pkg::COM_TOGGLE && match_a
       && !(wr_i && addr_i == twc_pkg::ADDR_CTRL_A))
      |=> (wave_a_o != $past(wave_a_o)))
      else $error("wave a did not toggle on match");

   a_set_b_match: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_NORMAL && com_b == twc_pkg::COM_SET && match_b)
      |=> wave_b_o)
      else $error("wave b not set on match");

   a_fast_bottom_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_FAST && com_a == twc_pkg::COM_CLEAR && at_bottom
       && !match_a) |=> wave_a_o)
      else $error("non-inverting output not set at bottom");

   a_pwm_toggle_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ((kind == twc_pkg::TWC_K_FAST || kind == twc_pkg::TWC_K_PHASE)
       && com_a == twc_pkg::COM_TOGGLE && !mode_high) |-> !wave_a_en_o)
      else $error("pwm toggle connected without high mode bit");

   a_phase_down_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_PHASE && com_a == twc_pkg::COM_CLEAR && match_a
       && down && cmp_a != top) |=> wave_a_o)
      else $error("phase pwm not set on down match");

   a_fast_top_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_FAST && com_a[1] && cmp_a == top && match_a
       && !at_bottom && $stable(ctrl_a)) |=> $stable(wave_a_o))
      else $error("match at top not ignored in fast pwm");

   a_phase_top_action: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_PHASE && com_b == twc_pkg::COM_SET && cmp_b == top
       && at_top) |=> wave_b_o)
      else $error("phase pwm top action missing");

   a_normal_max_ovf: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_NORMAL && count == twc_pkg::CNT_MAX)
      |=> (status[twc_pkg::ST_OVF] && count == twc_pkg::CNT_BOTTOM))
      else $error("normal mode overflow not flagged at max");

   a_phase_load_top: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_PHASE && !at_top && $stable(kind))
      |=> (cmp_b == $past(cmp_b)))
      else $error("phase pwm compare changed off top");

   a_fast_top_ovf: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (mode == twc_pkg::MODE_FAST_A && at_top) |=> status[twc_pkg::ST_OVF])
      else $error("mode 7 overflow not flagged at top");

   a_reserved_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (kind == twc_pkg::TWC_K_RSVD) |-> (!wave_a_en_o && !wave_b_en_o))
      else $error("reserved mode drives a pin");

   a_irq_follows: assert property (@(posedge clk_i) disable iff (!nrst_i)
      irq_o == |(status & mask))
      else $error("interrupt level mismatch");
endmodule // twc_top
`default_nettype wire

// ===== testbench/twc_pin_model.sv
// pin model for the port pin that carries a waveform output
`timescale 1ns/1ns
`default_nettype none
module twc_pin_model (
   input  wire logic dir_i,     // port direction bit
   input  wire logic port_i,    // port data latch
   input  wire logic wave_i,    // waveform level
   input  wire logic wave_en_i, // waveform owns pin
   output logic      pin_o      // level on the pin
);
   // driver needs direction
   // pull-up holds an undriven pin high rather than a guessed level
   assign pin_o = !dir_i ? 1'b1 : (wave_en_i ? wave_i : port_i);
endmodule // twc_pin_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the timer waveform output block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ********************************
   // signals, design and pin
   // ********************************
   logic       clk_i, nrst_i, wr_i, rd_i, dir_a, pin_a, irq_o;
   logic [7:0] addr_i, wdata_i, rdata_o;
   logic       wave_a_o, wave_a_en_o, wave_b_o, wave_b_en_o;
   int         err_total, n_compared, n;
   twc_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .wave_a_o(wave_a_o), .wave_a_en_o(wave_a_en_o),
      .wave_b_o(wave_b_o), .wave_b_en_o(wave_b_en_o), .irq_o(irq_o));
   twc_pin_model u_pin (.dir_i(dir_a), .port_i(1'b0), .wave_i(wave_a_o), .wave_en_i(wave_a_en_o),
      .pin_o(pin_a));
   // free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ********************************
   // shared tasks
   // ********************************
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      // let the write settle before anyone looks at enables
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, exp, input string what);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk({8'h00, rdata_o}, {8'h00, exp}, what);
   endtask
   // bounded wait for a level; n ends as cycles spent waiting
   task automatic await(input logic b, lvl);
      n = 0;
      while ((b ? wave_b_o : wave_a_o) !== lvl && n < 600) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n >= 600) begin
         err_total++;
         $display("Error at %0t: wave wait ran out", $time);
         print_verdict();
      end
   endtask
   // length of one stretch at level lvl
   task automatic span(input logic b, lvl, input int exp, input string what);
      await(b, lvl);
      await(b, !lvl);
      await(b, lvl);
      await(b, !lvl);
      chk(n[15:0], exp[15:0], what);
   endtask
   task automatic hold(input logic b, lvl, input string what);
      await(b, lvl);
      n = 0;
      repeat (260) begin
         @(posedge clk_i);
         #1 if ((b ? wave_b_o : wave_a_o) !== lvl) n++;
      end
      chk(n[15:0], 16'h0000, what);
   endtask
   // ********************************
   // scenarios
   // ********************************
   task automatic t_regs();
      rd(twc_pkg::ADDR_CTRL_A, 8'h00, "ctrl a reset");
      wr(twc_pkg::ADDR_CTRL_A, 8'hff);
      rd(twc_pkg::ADDR_CTRL_A, 8'hf3, "ctrl a read");
      chk({14'h0, wave_a_en_o, wave_b_en_o}, 16'h0003, "en both");
      wr(twc_pkg::ADDR_CTRL_A, 8'h10);
      chk({14'h0, wave_a_en_o, wave_b_en_o}, 16'h0001, "en b only");
      wr(twc_pkg::ADDR_CTRL_B, 8'hff);
      rd(twc_pkg::ADDR_CTRL_B, 8'h08, "ctrl b read");
      rd(8'hc0, 8'h00, "unmapped");
      $display("t_regs done");
   endtask
   task automatic t_nonpwm();
      wr(twc_pkg::ADDR_CTRL_B, 8'h00);
      wr(twc_pkg::ADDR_CMP_A, 8'h05);
      wr(twc_pkg::ADDR_CTRL_A, 8'h40);
      chk({15'h0, pin_a}, 16'h0001, "pin without direction");
      dir_a <= 1'b1;
      span(1'b0, 1'b1, 256, "normal toggle");
      chk({15'h0, pin_a}, {15'h0, wave_a_o}, "pin follows");
      wr(twc_pkg::ADDR_CTRL_A, 8'hb0);
      hold(1'b0, 1'b0, "clear a");
      hold(1'b1, 1'b1, "set b");
      wr(twc_pkg::ADDR_CTRL_A, 8'he0);
      hold(1'b0, 1'b1, "set a");
      hold(1'b1, 1'b0, "clear b");
      wr(twc_pkg::ADDR_CMP_A, 8'h09);
      wr(twc_pkg::ADDR_CTRL_A, 8'h52);
      span(1'b0, 1'b1, 10, "ctc toggle a");
      span(1'b1, 1'b0, 10, "ctc toggle b");
      $display("t_nonpwm done");
   endtask
   task automatic t_fast();
      wr(twc_pkg::ADDR_CMP_A, 8'h3f);
      wr(twc_pkg::ADDR_CMP_B, 8'h1f);
      wr(twc_pkg::ADDR_CTRL_A, 8'h83);
      span(1'b0, 1'b1, 63, "fast noninv");
      wr(twc_pkg::ADDR_CTRL_A, 8'hf3);
      span(1'b0, 1'b0, 63, "fast inv");
      span(1'b1, 1'b0, 31, "fast inv b");
      wr(twc_pkg::ADDR_CTRL_A, 8'h53);
      chk({14'h0, wave_a_en_o, wave_b_en_o}, 16'h0000, "pwm 01 off");
      wr(twc_pkg::ADDR_CMP_A, 8'h63);
      wr(twc_pkg::ADDR_CTRL_B, 8'h08);
      chk({15'h0, wave_a_en_o}, 16'h0001, "pwm 01 on");
      span(1'b0, 1'b1, 100, "mode 7 toggle");
      wr(twc_pkg::ADDR_CTRL_A, 8'ha3);
      span(1'b1, 1'b1, 31, "mode 7 b");
      hold(1'b0, 1'b1, "cmp at top");
      $display("t_fast done");
   endtask
   task automatic t_phase();
      wr(twc_pkg::ADDR_CTRL_B, 8'h00);
      wr(twc_pkg::ADDR_CMP_A, 8'h40);
      wr(twc_pkg::ADDR_CTRL_A, 8'h81);
      span(1'b0, 1'b1, 128, "phase mode 1");
      wr(twc_pkg::ADDR_CMP_A, 8'h64);
      wr(twc_pkg::ADDR_CMP_B, 8'h28);
      wr(twc_pkg::ADDR_CTRL_B, 8'h08);
      wr(twc_pkg::ADDR_CTRL_A, 8'ha1);
      span(1'b1, 1'b1, 80, "phase mode 5");
      hold(1'b0, 1'b0, "phase at top");
      wr(twc_pkg::ADDR_CTRL_A, 8'h80);
      chk({15'h0, wave_a_en_o}, 16'h0000, "mode 4");
      $display("t_phase done");
   endtask
   task automatic t_irq();
      wr(twc_pkg::ADDR_CTRL_B, 8'h00);
      wr(twc_pkg::ADDR_CTRL_A, 8'h00);
      wr(twc_pkg::ADDR_STATUS, 8'h07);
      wr(twc_pkg::ADDR_MASK, 8'h01);
      n = 0;
      while (irq_o !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk({15'h0, irq_o}, 16'h0001, "overflow irq");
      wr(twc_pkg::ADDR_STATUS, 8'h01);
      #1 chk({15'h0, irq_o}, 16'h0000, "irq cleared");
      wr(twc_pkg::ADDR_MASK, 8'h00);
      repeat (260) @(posedge clk_i);
      #1 chk({15'h0, irq_o}, 16'h0000, "irq masked");
      rd(twc_pkg::ADDR_STATUS, 8'h07, "status");
      $display("t_irq done");
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // reset held three cycles, then the scenarios
   initial begin
      {nrst_i, wr_i, rd_i, dir_a, addr_i, wdata_i} = '0;
      {err_total, n_compared, n} = '0;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_nonpwm();
      t_fast();
      t_phase();
      t_irq();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
